// *** src/oscillator_subsystem_register_bank.sv ***
// Write-only configuration bank of the oscillator subsystem.
// Assumes the controller end drives the link on the same sys_clk.
//
// Notes on behaviour
// R1 - Host word bits 2:0 pick subsystem; ours is zero
// R2 - Host bits 6:3 give subsystem register address
// R3 - Nine data bits occupy host bits 15:7
// R4 - Host keeps copies, rewrites whole register
// R5 - Master enable low switches everything off
// R6 - Bit 1 gates oscillators, bit 2 feedback buffer
// R7 - Bit 3 gates output stage and divider only
// R8 - Bit 5 separately enables the output stage
// R9 - Ratio 0 mutes, 1 passes, even divides
// R10 - Odd ratio rounds down; above 62 gives 62
// R11 - Priority 01 low current, 11 low noise
// R12 - Reset leaves low-current priority selected
// R13 - Config bits 2,3 enable positive, negative legs
// R14 - Config bit 4 selects internal termination
// R15 - Config bit 5 raises output termination
// R16 - Mute mode 00 mutes at zero ratio
// R17 - Host writes calibration registers with defaults only
// R18 - Reached only through host register five
// R19 - Transfer on completed write, identifier zero only
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
module oscillator_subsystem_register_bank (
  vco_link_if.bank   link,
  output logic       osc_on,
  output logic       fb_buf_on,
  output logic       out_div_on,
  output logic       out_stage_on,
  output logic [5:0] div_ratio,
  output logic       out_muted,
  output logic [1:0] priority_mode,
  output logic       positive_output_leg,
  output logic       negative_output_leg,
  output logic       internal_term,
  output logic       term_raise,
  output logic [1:0] mute_mode,
  output logic [8:0] cal_bias,
  output logic [8:0] cf_cal
);
  logic [8:0] enables_ff;
  logic [8:0] divider_ff;
  logic [8:0] config_ff;
  logic [8:0] cal_bias_ff;
  logic [8:0] cf_cal_ff;

  // Field extraction from the packed host word
  wire [2:0] subsystem_identifier = link.wr_word[vco_cfg_pkg::ID_LSB +: vco_cfg_pkg::ID_W]; // [R1]
  wire [3:0] reg_addr  = link.wr_word[vco_cfg_pkg::RADDR_LSB +: vco_cfg_pkg::RADDR_W]; // [R2]
  wire [8:0] reg_data  = link.wr_word[vco_cfg_pkg::DATA_LSB +: vco_cfg_pkg::DATA_W]; // [R3]

  wire hit = link.wr_pulse
           && (link.host_addr == vco_cfg_pkg::HOST_IND_ADDR)      // [R18]
           && (subsystem_identifier == vco_cfg_pkg::OSC_SUBSYS_ID); // [R19]

  wire wr_enables  = hit && (reg_addr == vco_cfg_pkg::REG_ENABLES);
  wire wr_divider  = hit && (reg_addr == vco_cfg_pkg::REG_DIVIDER);
  wire wr_config   = hit && (reg_addr == vco_cfg_pkg::REG_CONFIG);
  wire wr_cal_bias = hit && (reg_addr == vco_cfg_pkg::REG_CAL_BIAS);
  wire wr_cf_cal   = hit && (reg_addr == vco_cfg_pkg::REG_CF_CAL);

  // Whole register replaced per write; no read-back exists
  always_ff @(posedge link.sys_clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      enables_ff  <= vco_cfg_pkg::RST_ENABLES;
      divider_ff  <= vco_cfg_pkg::RST_DIVIDER;
      config_ff   <= vco_cfg_pkg::RST_CONFIG; // [R12]
      cal_bias_ff <= vco_cfg_pkg::RST_CAL_BIAS;
      cf_cal_ff   <= vco_cfg_pkg::RST_CF_CAL;
    end else begin
      if (wr_enables) begin
        enables_ff <= reg_data; // [R19]
      end
      if (wr_divider) begin
        divider_ff <= reg_data;
      end
      if (wr_config) begin
        config_ff <= reg_data;
      end
      if (wr_cal_bias) begin
        cal_bias_ff <= reg_data;
      end
      if (wr_cf_cal) begin
        cf_cal_ff <= reg_data;
      end
    end
  end

  // Block gating
  wire master_on = enables_ff[vco_cfg_pkg::EN_MASTER]; // [R5]
  wire io_on     = master_on && enables_ff[vco_cfg_pkg::EN_IO_MASTER]; // [R7]
  assign osc_on       = master_on && enables_ff[vco_cfg_pkg::EN_OSC]; // [R6]
  assign fb_buf_on    = master_on && enables_ff[vco_cfg_pkg::EN_FB_BUF]; // [R6]
  assign out_div_on   = io_on; // [R7]
  assign out_stage_on = io_on && enables_ff[vco_cfg_pkg::EN_OUT_STAGE]; // [R8]

  wire [5:0] legal_ratio;

  ratio_legalizer u_ratio (
    .ratio_in  (divider_ff[vco_cfg_pkg::DIV_LSB +: vco_cfg_pkg::DIV_W]),
    .ratio_out (legal_ratio)
  );

  assign div_ratio = legal_ratio; // [R9] [R10]

  // Config fields
  assign priority_mode       = config_ff[vco_cfg_pkg::PRIO_LSB +: 2]; // [R11]
  assign positive_output_leg = out_stage_on && config_ff[vco_cfg_pkg::CFG_POS_EN]; // [R13]
  assign negative_output_leg = out_stage_on && config_ff[vco_cfg_pkg::CFG_NEG_EN]; // [R13]
  assign internal_term       = config_ff[vco_cfg_pkg::CFG_INT_TERM]; // [R14]
  assign term_raise          = config_ff[vco_cfg_pkg::CFG_TERM_RAISE]; // [R15]
  assign mute_mode           = config_ff[vco_cfg_pkg::MUTE_LSB +: 2];

  // Other mute codes also mute whenever the output stage is off
  wire ratio_zero = (legal_ratio == 6'h00);
  assign out_muted = (mute_mode == vco_cfg_pkg::MUTE_ON_ZERO)
                   ? ratio_zero                        // [R9] [R16]
                   : (ratio_zero || !out_stage_on);

  assign cal_bias = cal_bias_ff;
  assign cf_cal   = cf_cal_ff;
endmodule

// *** src/vco_cfg_pkg.sv ***
// Constants shared by the controller end and the oscillator register bank end.
// Assumes one clock domain, sys_clk, on both ends.
package vco_cfg_pkg;
  // Host-side indirect register of the synthesizer map
  localparam logic [4:0] HOST_IND_ADDR  = 5'h05;
  localparam int         ID_LSB         = 0;
  localparam int         ID_W           = 3;
  localparam logic [2:0] OSC_SUBSYS_ID  = 3'h0;
  localparam int         RADDR_LSB      = 3;
  localparam int         RADDR_W        = 4;
  localparam int         DATA_LSB       = 7;
  localparam int         DATA_W         = 9;
  localparam int         WORD_W         = 16;

  // Subsystem register addresses
  localparam logic [3:0] REG_ENABLES    = 4'h1;
  localparam logic [3:0] REG_DIVIDER    = 4'h2;
  localparam logic [3:0] REG_CONFIG     = 4'h3;
  localparam logic [3:0] REG_CAL_BIAS   = 4'h4;
  localparam logic [3:0] REG_CF_CAL     = 4'h5;
  localparam int         NUM_REGS       = 5;

  // Reset values
  localparam logic [8:0] RST_ENABLES    = 9'h1BF;
  localparam logic [8:0] RST_DIVIDER    = 9'h001;
  localparam logic [8:0] RST_CONFIG     = 9'h091;
  localparam logic [8:0] RST_CAL_BIAS   = 9'h0C9;
  localparam logic [8:0] RST_CF_CAL     = 9'h0AA;

  // Enables register fields
  localparam int EN_MASTER    = 0;
  localparam int EN_OSC       = 1;
  localparam int EN_FB_BUF    = 2;
  localparam int EN_IO_MASTER = 3;
  localparam int EN_OUT_STAGE = 5;

  // Divider register fields
  localparam int         DIV_LSB        = 0;
  localparam int         DIV_W          = 6;
  localparam logic [5:0] DIV_MAX        = 6'h3E;

  // Config register fields
  localparam int         PRIO_LSB       = 0;
  localparam logic [1:0] PRIO_LOW_POWER = 2'h1;
  localparam logic [1:0] PRIO_LOW_NOISE = 2'h3;
  localparam int         CFG_POS_EN     = 2;
  localparam int         CFG_NEG_EN     = 3;
  localparam int         CFG_INT_TERM   = 4;
  localparam int         CFG_TERM_RAISE = 5;
  localparam int         MUTE_LSB       = 7;
  localparam logic [1:0] MUTE_ON_ZERO   = 2'h0;

  // Controller Wishbone map (byte addresses)
  localparam logic [7:0] WB_STATUS      = 8'h00;
  localparam logic [7:0] WB_SHADOW_BASE = 8'h04;
  localparam int         WB_ADR_W       = 8;
endpackage

// *** src/vco_link_if.sv ***
// Indirect write path from the controller to the oscillator register bank.
// Both ends sit on sys_clk; wr_pulse is one cycle wide.
`timescale 1ns/1ps
interface vco_link_if (
  input wire logic sys_clk,
  input wire logic rst_n
);
  logic        wr_pulse;
  logic [4:0]  host_addr;
  logic [15:0] wr_word;

  modport ctrl (
    input  sys_clk,
    input  rst_n,
    output wr_pulse,
    output host_addr,
    output wr_word
  );

  modport bank (
    input  sys_clk,
    input  rst_n,
    input  wr_pulse,
    input  host_addr,
    input  wr_word
  );
endinterface

// *** src/ratio_legalizer.sv ***
// Folds a written divide ratio onto the set the output divider supports.
// Pure combinational; used by the register bank.
`timescale 1ns/1ps
module ratio_legalizer (
  input  wire logic [5:0] ratio_in,
  output wire logic [5:0] ratio_out
);
  // 0 and 1 pass; odd rounds down; 63 lands on 62 by the same rule
  wire small_ratio = (ratio_in <= 6'h01);
  assign ratio_out = small_ratio ? ratio_in : {ratio_in[5:1], 1'b0}; // [R10]
endmodule

// *** src/vco_cfg_ctrl.sv ***
// Controller end: classic Wishbone slave holding shadow copies of the
// subsystem registers, packing each change into one indirect host write.
`timescale 1ns/1ps
module vco_cfg_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  vco_link_if.ctrl         link
);
  logic [8:0]  shadow_ff [vco_cfg_pkg::NUM_REGS];
  logic        ack_ff;
  logic [31:0] rdata_ff;
  logic        pulse_ff;
  logic [15:0] word_ff;
  logic [7:0]  sent_cnt_ff;

  wire       req      = wb_cyc_i && wb_stb_i;
  wire [7:0] rel_adr  = wb_adr_i - vco_cfg_pkg::WB_SHADOW_BASE;
  wire [5:0] idx      = rel_adr[7:2];
  wire       is_shad  = (wb_adr_i >= vco_cfg_pkg::WB_SHADOW_BASE)
                      && (idx < 6'(vco_cfg_pkg::NUM_REGS)) && (wb_adr_i[1:0] == 2'h0);
  wire       is_stat  = (wb_adr_i == vco_cfg_pkg::WB_STATUS);
  wire [2:0] sidx     = idx[2:0];
  // Write lands at the edge where the master sees ack
  wire       do_write = req && ack_ff && wb_we_i && is_shad;

  // Byte lanes: low byte, then bit 8 in lane 1
  wire [8:0] old_val  = shadow_ff[sidx];
  wire [8:0] lane_val = {wb_sel_i[1] ? wb_dat_i[8] : old_val[8],
                         wb_sel_i[0] ? wb_dat_i[7:0] : old_val[7:0]};
  // Unsupported priority codes folded onto legal ones
  wire [8:0] cfg_val  = {lane_val[8:1], 1'b1}; // [R11]
  wire       fixed    = (sidx == 3'(vco_cfg_pkg::REG_CAL_BIAS - 4'h1))
                     || (sidx == 3'(vco_cfg_pkg::REG_CF_CAL - 4'h1));
  wire       is_cfg   = (sidx == 3'(vco_cfg_pkg::REG_CONFIG - 4'h1));
  wire [8:0] new_val  = fixed ? old_val : (is_cfg ? cfg_val : lane_val); // [R17]
  wire [3:0] sub_addr = {1'b0, sidx} + 4'h1;
  wire [15:0] packed_word = {new_val, sub_addr, vco_cfg_pkg::OSC_SUBSYS_ID}; // [R1] [R2] [R3]

  wire [31:0] rd_mux = is_shad ? {23'h0, shadow_ff[sidx]}
                     : is_stat ? {8'h00, sent_cnt_ff, word_ff} : 32'h0;

  // Shadows start at the bank's own reset values
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_ff[0] <= vco_cfg_pkg::RST_ENABLES;
      shadow_ff[1] <= vco_cfg_pkg::RST_DIVIDER;
      shadow_ff[2] <= vco_cfg_pkg::RST_CONFIG;
      shadow_ff[3] <= vco_cfg_pkg::RST_CAL_BIAS;
      shadow_ff[4] <= vco_cfg_pkg::RST_CF_CAL;
    end else if (do_write) begin
      shadow_ff[sidx] <= new_val; // [R4]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      ack_ff   <= req && !ack_ff;
      rdata_ff <= rd_mux;
    end
  end

  // Every shadow write resends the full nine bits
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_ff    <= 1'b0;
      word_ff     <= 16'h0000;
      sent_cnt_ff <= 8'h00;
    end else begin
      pulse_ff <= do_write; // [R4]
      if (do_write) begin
        word_ff     <= packed_word;
        sent_cnt_ff <= sent_cnt_ff + 8'h01;
      end
    end
  end

  assign wb_ack_o       = ack_ff;
  assign wb_dat_o       = rdata_ff;
  assign link.wr_pulse  = pulse_ff;
  assign link.host_addr = vco_cfg_pkg::HOST_IND_ADDR; // [R18]
  assign link.wr_word   = word_ff;
endmodule

// *** dv/vco_link_properties.sv ***
// Link and bank output checks for the oscillator configuration path.
// Instantiated by the bench beside the link interface; one clock domain.
`timescale 1ns/1ps
module vco_link_properties (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        wr_pulse,
  input wire logic [4:0]  host_addr,
  input wire logic [15:0] wr_word,
  input wire logic        osc_on,
  input wire logic        out_stage_on,
  input wire logic [5:0]  div_ratio,
  input wire logic        out_muted,
  input wire logic [1:0]  priority_mode,
  input wire logic        positive_output_leg
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  function automatic logic [5:0] fold(logic [5:0] r);
    return (r > 6'h3E) ? 6'h3E : ((r > 6'h01) ? {r[5:1], 1'b0} : r);
  endfunction

  a_host_addr_five: assert property (host_addr == 5'h05)
    else $error("host address not five");
  a_id_zero: assert property (wr_pulse |-> wr_word[2:0] == 3'h0)
    else $error("nonzero subsystem identifier");
  a_reg_in_range: assert property (wr_pulse |-> wr_word[6:3] inside {[4'h1:4'h5]})
    else $error("register address out of range");
  a_pulse_single: assert property (wr_pulse |=> !wr_pulse)
    else $error("write pulse too long");
  a_word_held: assert property ($changed(wr_word) |-> wr_pulse)
    else $error("word changed without pulse");
  a_master_off: assert property (wr_pulse && wr_word[6:3] == 4'h1 && !wr_word[7]
    |=> !osc_on && !out_stage_on) else $error("master enable low left blocks on");
  a_divider_fold: assert property (wr_pulse && wr_word[6:3] == 4'h2
    |=> div_ratio == fold($past(wr_word[12:7]))) else $error("ratio not folded");
  a_priority_set: assert property (wr_pulse && wr_word[6:3] == 4'h3
    |=> priority_mode == $past(wr_word[8:7])) else $error("priority wrong");
  a_prio_legal: assert property (wr_pulse && wr_word[6:3] == 4'h3 |-> wr_word[7])
    else $error("unsupported priority code sent");
  a_leg_gated: assert property (positive_output_leg |-> out_stage_on)
    else $error("leg on with stage off");
  a_zero_mutes: assert property (div_ratio == 6'h00 |-> out_muted)
    else $error("zero ratio not muted");

  cover property (wr_pulse && wr_word[6:3] == 4'h2);
  cover property (out_muted);
  cover property (!osc_on);
endmodule

// *** dv/vco_subsystem_config_regs_bench.sv ***
// Bench joining controller and register bank through the link interface.
// Wishbone master tasks drive the controller; a monitor checks queued notes.
`timescale 1ns/1ps
module vco_subsystem_config_regs_bench;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [31:0] dat     = 32'h0;
  logic [3:0]  sel     = 4'h3;
  logic [31:0] dat_o;
  logic        ack;
  logic        osc, fb, odiv, stage, muted, pos, neg, iterm, traise;
  logic [5:0]  ratio, f;
  logic [1:0]  prio, mmode;
  logic [8:0]  cal, cf, c;
  logic [31:0] exp_word[$], exp_rd[$];
  logic [15:0] last_word = 16'h0000;
  logic [7:0]  sent = 8'h00;
  int          bad_count = 0;
  int          total_checks = 0;
  logic [8:0]  en_tab[7] = '{9'h1B7, 9'h1BD, 9'h1BB, 9'h1BE, 9'h1DF, 9'h1A7, 9'h0FE};
  logic [8:0]  rst_tab[5] = '{9'h1BF, 9'h001, 9'h091, 9'h0C9, 9'h0AA};

  always #2 sys_clk = ~sys_clk;

  vco_link_if link (.sys_clk(sys_clk), .rst_n(rst_n));
  vco_cfg_ctrl vco_cfg_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .link(link));
  oscillator_subsystem_register_bank oscillator_subsystem_register_bank_inst (.link(link), .osc_on(osc), .fb_buf_on(fb),
    .out_div_on(odiv), .out_stage_on(stage), .div_ratio(ratio), .out_muted(muted),
    .priority_mode(prio), .positive_output_leg(pos), .negative_output_leg(neg),
    .internal_term(iterm), .term_raise(traise), .mute_mode(mmode), .cal_bias(cal),
    .cf_cal(cf));
  vco_link_properties vco_link_properties_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .wr_pulse(link.wr_pulse), .host_addr(link.host_addr), .wr_word(link.wr_word),
    .osc_on(osc), .out_stage_on(stage), .div_ratio(ratio), .out_muted(muted),
    .priority_mode(prio), .positive_output_leg(pos));

  task automatic check(logic [31:0] seen, logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic give_verdict();
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Slave answers in its own time; ack or the 20-cycle bound ends a wait
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      bad_count++;
      give_verdict();
    end
    {cyc, stb} <= 2'b00;
  endtask

  // Notes the word the link must carry, then writes and lets the bank settle
  task automatic wr_raw(logic [7:0] a, logic [31:0] d, logic [15:0] w);
    exp_word.push_back({16'h0, w});
    last_word = w;
    sent++;
    wb(1'b1, a, d);
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic wr(int i, logic [8:0] d);
    wr_raw(8'(4 * i), {23'h0, d}, {(i == 3) ? (d | 9'h001) : d, i[3:0], 3'h0});
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    exp_rd.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask

  task automatic check_en(logic [8:0] e);
    check({osc, fb, odiv, stage}, {e[0] & e[1], e[0] & e[2], e[0] & e[3], &{e[0], e[3], e[5]}});
  endtask

  task automatic chk_reset();
    check({osc, fb, odiv, stage, muted, pos, neg, iterm, traise}, 9'h1E2);
    check({ratio, prio, mmode}, {6'h01, 2'h1, 2'h1});
    check({cal, cf}, {9'h0C9, 9'h0AA});
    check({link.wr_pulse, link.wr_word}, 17'h0);
  endtask

  always @(posedge sys_clk) begin
    if (rst_n && link.wr_pulse === 1'b1)
      check(link.wr_word, exp_word.size() ? exp_word.pop_front() : 32'hFFFFFFFF);
    if (rst_n && ack === 1'b1 && !we)
      check(dat_o, exp_rd.size() ? exp_rd.pop_front() : 32'hFFFFFFFF);
  end

  initial begin
    void'($urandom(55720));
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk_reset();
    for (int i = 1; i < 6; i++) rd(8'(4 * i), {23'h0, rst_tab[i - 1]});
    rd(8'h40, 32'h0);
    wb(1'b1, 8'h40, 32'h1FF);
    wr(1, 9'h1DF);
    check(link.wr_word, 16'hEF88);
    foreach (en_tab[k]) begin
      c = (k > 4) ? 9'($urandom) : en_tab[k];
      wr(1, c);
      check_en(c);
    end
    wr(1, 9'h1BF);
    // Lane 1 off: bit 8 keeps the shadow's 1, low byte clears bit 5
    sel <= 4'h1;
    wr_raw(8'h04, 32'h0DF, 16'hEF88);
    check(stage, 1'b0);
    sel <= 4'h3;
    wr(1, 9'h1BF);
    for (int r = 0; r < 64; r++) begin
      wr(2, {3'($urandom), 6'(r)});
      f = (r > 62) ? 6'h3E : ((r > 1) ? 6'(r & 62) : 6'(r));
      check({ratio, muted}, {f, f == 6'h00});
    end
    repeat (6) begin
      c = 9'($urandom) & 9'h1BF | 9'h001;
      wr(3, c);
      check({prio, pos, neg, iterm, traise, mmode}, {c[1:0], c[2], c[3], c[4], c[5], c[8:7]});
    end
    wr(1, 9'h1DF);
    wr(3, 9'h00D);
    check({muted, pos, neg}, 3'b000);
    wr(1, 9'h1BF);
    check({pos, neg}, 2'b11);
    wr(4, 9'h0C9);
    wr(5, 9'h0AA);
    // Non-default data to a fixed register still sends the default
    wr_raw(8'h10, 32'h1FF, {9'h0C9, 4'h4, 3'h0});
    check({cal, cf}, {9'h0C9, 9'h0AA});
    rd(8'h00, {8'h0, sent, last_word});
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk_reset();
    check(exp_word.size() + exp_rd.size(), 0);
    give_verdict();
  end
endmodule
